// *** hdl/slr_lane_cfg_regs.sv ***
// ---------------------------------------------------------------------------
// paged register bank for lane readback and link parameters
// ---------------------------------------------------------------------------
// holds the page selector, core soft reset bit and per-link register copies.
// assumes a plain register port with read data one cycle after the strobe.
`timescale 1ns/1ns
module slr_lane_cfg_regs
  import slr_pkg::*;
#(
  parameter int unsigned LINKS = 2
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic [11:0]           reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic [LINKS*2-1:0]    ilas_valid,
  input  wire logic [LINKS*8-1:0]    ilas_index,
  input  wire logic [LINKS*16-1:0]   ilas_octet,
  input  wire logic                  lane0_info_valid,
  input  wire logic                  lane0_adj_dir,
  input  wire logic                  lane0_ph_adj,
  output logic      [LINKS*8-1:0]    cfg_device_number,
  output logic      [LINKS*8-1:0]    cfg_bank_number,
  output logic      [LINKS*5-1:0]    cfg_lane_number,
  output logic      [LINKS-1:0]      cfg_descramble_en,
  output logic      [LINKS*5-1:0]    cfg_lane_count_m1,
  output logic      [LINKS*8-1:0]    cfg_octets_m1,
  output logic                       multiframe_adjust_direction,
  output logic                       phase_adjust_request,
  output logic                       deframer_core_soft_reset,
  output logic      [LINKS*2-1:0]    sum_mismatch
);

  localparam int unsigned PAGE_W = (LINKS > 1) ? $clog2(LINKS) : 1;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        rdata;
    logic [PAGE_W-1:0] page;
    logic              core_rst;
  } slr_top_t;

  slr_top_t st_ff;
  slr_top_t nxt_st;

  slr_sel_t   wr_sel;
  slr_sel_t   link_sel  [LINKS];
  logic [4:0] lane_lid  [LINKS][2];
  logic [7:0] lane_rsum [LINKS][2];
  logic [7:0] lane_csum [LINKS][2];
  logic [7:0] dev_reg   [LINKS];
  logic [7:0] bank_reg  [LINKS];
  logic [7:0] lid_reg   [LINKS];
  logic [7:0] scr_reg   [LINKS];
  logic [7:0] frm_reg   [LINKS];
  logic [7:0] rd_val;

  // -------------------------------------------------------------------------
  // write decode
  // -------------------------------------------------------------------------
  always_comb begin
    wr_sel = SEL_NONE;
    if (reg_wr) begin
      unique case (reg_addr)
        ADR_DEV:  wr_sel = SEL_DEV;
        ADR_BANK: wr_sel = SEL_BANK;
        ADR_LANE_NUMBER_FIELD: wr_sel = SEL_LANE_NUMBER_FIELD;
        ADR_SCR:  wr_sel = SEL_SCR;
        ADR_FRM:  wr_sel = SEL_FRM;
        default:  wr_sel = SEL_NONE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // per-link copies
  // -------------------------------------------------------------------------
  genvar gl;
  genvar gn;
  generate
    for (gl = 0; gl < LINKS; gl++) begin : g_link
      // only the copy of the selected page takes the write
      assign link_sel[gl] = (st_ff.page == PAGE_W'(gl)) ? wr_sel : SEL_NONE;

      slr_link_cfg #(
        .HAS_ADJ (gl == 0)
      ) u_cfg (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .wr_sel        (link_sel[gl]),
        .wr_data       (reg_wdata),
        .adj_load      (lane0_info_valid),
        .adj_dir_in    (lane0_adj_dir),
        .ph_adj_in     (lane0_ph_adj),
        .device_number (dev_reg[gl]),
        .bank_number   (bank_reg[gl]),
        .lane_reg      (lid_reg[gl]),
        .scr_reg       (scr_reg[gl]),
        .frame_reg     (frm_reg[gl])
      );

      assign cfg_device_number[gl*8 +: 8] = dev_reg[gl];
      assign cfg_bank_number[gl*8 +: 8]   = bank_reg[gl];
      assign cfg_lane_number[gl*5 +: 5]   = lid_reg[gl][4:0];
      assign cfg_descramble_en[gl]        = scr_reg[gl][POS_SCR];
      assign cfg_lane_count_m1[gl*5 +: 5] = scr_reg[gl][4:0];
      assign cfg_octets_m1[gl*8 +: 8]     = frm_reg[gl];

      for (gn = 0; gn < 2; gn++) begin : g_lane
        slr_lane_capture u_cap (
          .ref_clk      (ref_clk),
          .reset        (reset),
          .ilas_valid   (ilas_valid[gl*2+gn]),
          .ilas_index   (ilas_index[(gl*2+gn)*4 +: 4]),
          .ilas_octet   (ilas_octet[(gl*2+gn)*8 +: 8]),
          .lane_number  (lane_lid[gl][gn]),
          .rx_sum       (lane_rsum[gl][gn]),
          .calc_sum     (lane_csum[gl][gn]),
          .sum_mismatch (sum_mismatch[gl*2+gn])
        );
      end
    end
  endgenerate

  // link 0 alone carries the multiframe adjust controls
  assign multiframe_adjust_direction = lid_reg[0][POS_ADJ_DIR];
  assign phase_adjust_request        = lid_reg[0][POS_PH_ADJ];

  // -------------------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------------------
  always_comb begin
    rd_val = RST_RO;
    unique case (reg_addr)
      ADR_LINK_PAGE: rd_val[POS_PAGE +: PAGE_W] = st_ff.page;
      ADR_CORE_CTRL: rd_val[POS_CORE_RST] = st_ff.core_rst;
      ADR_L6_LID:    rd_val[4:0] = lane_lid[st_ff.page][0];
      ADR_L6_RSUM:   rd_val = lane_rsum[st_ff.page][0];
      ADR_L6_CSUM:   rd_val = lane_csum[st_ff.page][0];
      ADR_L7_LID:    rd_val[4:0] = lane_lid[st_ff.page][1];
      ADR_L7_RSUM:   rd_val = lane_rsum[st_ff.page][1];
      ADR_L7_CSUM:   rd_val = lane_csum[st_ff.page][1];
      ADR_DEV:       rd_val = dev_reg[st_ff.page];
      ADR_BANK:      rd_val = bank_reg[st_ff.page];
      ADR_LANE_NUMBER_FIELD:      rd_val = lid_reg[st_ff.page];
      ADR_SCR:       rd_val = scr_reg[st_ff.page];
      ADR_FRM:       rd_val = frm_reg[st_ff.page];
      default:       rd_val = RST_RO;
    endcase
  end

  // -------------------------------------------------------------------------
  // page, core reset and read data registers
  // -------------------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = reg_rd ? rd_val : RST_RO;
    if (reg_wr && reg_addr == ADR_LINK_PAGE) begin
      nxt_st.page = reg_wdata[POS_PAGE +: PAGE_W];
    end
    if (reg_wr && reg_addr == ADR_CORE_CTRL) begin
      nxt_st.core_rst = reg_wdata[POS_CORE_RST];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '{rdata: RST_RO, page: '0, core_rst: RST_CORE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata                = st_ff.rdata;
  // software holds the core here while it changes identifiers
  assign deframer_core_soft_reset = st_ff.core_rst;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero after idle cycle");

  a_page_write: assert property (
    reg_wr && reg_addr == ADR_LINK_PAGE |=> st_ff.page == $past(reg_wdata[PAGE_W-1:0]))
    else $error("page select not updated");

  a_dev_paged: assert property (
    reg_wr && reg_addr == ADR_DEV && st_ff.page == '0 |=> cfg_device_number[7:0] == $past(reg_wdata))
    else $error("device number not written to selected page");

  a_lid_bit7: assert property (
    reg_rd && reg_addr == ADR_LANE_NUMBER_FIELD |=> reg_rdata[7] == 1'b0)
    else $error("reserved lane register bit not zero");

  a_scr_resv: assert property (
    reg_rd && reg_addr == ADR_SCR |=> reg_rdata[6:5] == 2'b00)
    else $error("reserved lane count bits not zero");

  a_adj_link1: assert property (
    reg_rd && reg_addr == ADR_LANE_NUMBER_FIELD && st_ff.page != '0 |=> reg_rdata[6:5] == 2'b00)
    else $error("adjust bits present on link other than 0");

  a_adj_lane0: assert property (
    lane0_info_valid |=> multiframe_adjust_direction == $past(lane0_adj_dir)
      && phase_adjust_request == $past(lane0_ph_adj))
    else $error("lane 0 adjust information not taken");

  a_scr_reset: assert property (
    $past(reset) && !$past(reg_wr) |-> cfg_descramble_en == {LINKS{1'b1}} && cfg_lane_count_m1[4:0] == 5'h07)
    else $error("descramble or lane count reset value wrong");

  a_lid6_read: assert property (
    reg_rd && reg_addr == ADR_L6_LID |=> reg_rdata[7:5] == 3'b000)
    else $error("reserved lane 6 number bits not zero");

  c_page_switch: cover property (reg_wr && reg_addr == ADR_LINK_PAGE ##1 reg_rd && reg_addr == ADR_DEV);
  c_lane0_info:  cover property (lane0_info_valid ##1 reg_rd && reg_addr == ADR_LANE_NUMBER_FIELD);
  c_mismatch:    cover property ($rose(sum_mismatch[0]));

endmodule

// *** hdl/slr_pkg.sv ***
// ---------------------------------------------------------------------------
// constants for the lane configuration register bank
// ---------------------------------------------------------------------------
// holds offsets, field positions, reset values and the write selector type.
// assumes 12-bit register addresses and 8-bit register data.
//
// Function
// - every register access except page select and core control reaches the copy of the link chosen by the page register
// - lanes 6 and 7 show received 5-bit lane number, read-only, reset zero
// - lanes 6 and 7 capture received checksum octet, read-only, reset zero
// - lanes 6 and 7 show locally computed checksum, read-only, reset zero
// - 8-bit read/write device number, reset zero
// - 8-bit read/write bank number, reset zero
// - lane register bit 6 is read/write multiframe adjust direction, reset zero
// - adjust direction is taken from link information arriving on lane 0
// - lane register bit 5 is read/write phase adjust request, reset zero
// - lane register bits 4:0 hold lane number; bit 7 reads zero
// - adjust direction and phase adjust exist only on link 0
// - bit 7 of lane count register enables descrambling, resets to one
// - lane count minus one in bits 4:0 resets to 7; bits 6:5 read zero
// - 8-bit octets per frame minus one, read/write, reset zero
package slr_pkg;

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [11:0] ADR_LINK_PAGE = 12'h300;
  localparam logic [11:0] ADR_CORE_CTRL = 12'h475;
  localparam logic [11:0] ADR_L6_LID    = 12'h43a;
  localparam logic [11:0] ADR_L6_RSUM   = 12'h43d;
  localparam logic [11:0] ADR_L6_CSUM   = 12'h43e;
  localparam logic [11:0] ADR_L7_LID    = 12'h442;
  localparam logic [11:0] ADR_L7_RSUM   = 12'h445;
  localparam logic [11:0] ADR_L7_CSUM   = 12'h446;
  localparam logic [11:0] ADR_DEV       = 12'h450;
  localparam logic [11:0] ADR_BANK      = 12'h451;
  localparam logic [11:0] ADR_LANE_NUMBER_FIELD      = 12'h452;
  localparam logic [11:0] ADR_SCR       = 12'h453;
  localparam logic [11:0] ADR_FRM       = 12'h454;

  // -------------------------------------------------------------------------
  // field positions and masks
  // -------------------------------------------------------------------------
  localparam int unsigned POS_PAGE     = 0;
  localparam int unsigned POS_CORE_RST = 3;
  localparam int unsigned POS_ADJ_DIR  = 6;
  localparam int unsigned POS_PH_ADJ   = 5;
  localparam int unsigned POS_SCR      = 7;
  localparam logic [7:0]  MASK_LID_ADJ = 8'h7f;
  localparam logic [7:0]  MASK_LID_NO  = 8'h1f;
  localparam logic [7:0]  MASK_SCR     = 8'h9f;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] RST_DEV      = 8'h00;
  localparam logic [7:0] RST_BANK     = 8'h00;
  localparam logic [7:0] RST_LANE_NUMBER_FIELD     = 8'h00;
  localparam logic [7:0] RST_SCR      = 8'h87;
  localparam logic [7:0] RST_FRM      = 8'h00;
  localparam logic [7:0] RST_RO       = 8'h00;
  localparam logic       RST_CORE_RST = 1'b0;

  // -------------------------------------------------------------------------
  // ilas configuration octet positions
  // -------------------------------------------------------------------------
  localparam logic [3:0] ILAS_IDX_FIRST = 4'h0;
  localparam logic [3:0] ILAS_IDX_LID   = 4'h2;
  localparam logic [3:0] ILAS_IDX_FCHK  = 4'hd;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DEV,
    SEL_BANK,
    SEL_LANE_NUMBER_FIELD,
    SEL_SCR,
    SEL_FRM
  } slr_sel_t;

endpackage

// *** hdl/slr_lane_capture.sv ***
// ---------------------------------------------------------------------------
// ilas capture for one lane of one link
// ---------------------------------------------------------------------------
// takes the lane number and checksum octet out of the configuration octets.
// assumes octets arrive in index order, index 0 first, with a valid strobe.
`timescale 1ns/1ns
module slr_lane_capture
  import slr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       ilas_valid,
  input  wire logic [3:0] ilas_index,
  input  wire logic [7:0] ilas_octet,
  output logic      [4:0] lane_number,
  output logic      [7:0] rx_sum,
  output logic      [7:0] calc_sum,
  output logic            sum_mismatch
);

  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] lid;
    logic [7:0] rsum;
    logic [7:0] csum;
    logic       mism;
  } slr_lane_t;

  slr_lane_t st_ff;
  slr_lane_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ilas_valid) begin
      // running modulo-256 sum of the octets ahead of the checksum octet
      if (ilas_index == ILAS_IDX_FIRST) begin
        nxt_st.acc = ilas_octet;
      end else if (ilas_index < ILAS_IDX_FCHK) begin
        nxt_st.acc = st_ff.acc + ilas_octet;
      end
      if (ilas_index == ILAS_IDX_LID) begin
        nxt_st.lid = ilas_octet[4:0];
      end
      if (ilas_index == ILAS_IDX_FCHK) begin
        nxt_st.rsum = ilas_octet;
        nxt_st.csum = st_ff.acc;
        nxt_st.mism = (ilas_octet != st_ff.acc);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lane_number  = st_ff.lid;
  assign rx_sum       = st_ff.rsum;
  assign calc_sum     = st_ff.csum;
  assign sum_mismatch = st_ff.mism;

  a_sum_capture: assert property (@(posedge ref_clk) disable iff (reset)
    ilas_valid && ilas_index == ILAS_IDX_FCHK |=> calc_sum == $past(st_ff.acc) && rx_sum == $past(ilas_octet))
    else $error("checksum pair not captured");
  a_lid_capture: assert property (@(posedge ref_clk) disable iff (reset)
    ilas_valid && ilas_index == ILAS_IDX_LID |=> lane_number == $past(ilas_octet[4:0]))
    else $error("lane number not captured");

endmodule

// *** hdl/slr_link_cfg.sv ***
// ---------------------------------------------------------------------------
// programmed link parameters of one link page
// ---------------------------------------------------------------------------
// holds device, bank, lane, lane count and frame size registers.
// assumes the parent decodes the address and page into a write selector.
`timescale 1ns/1ns
module slr_link_cfg
  import slr_pkg::*;
#(
  parameter bit HAS_ADJ = 1'b1
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire slr_sel_t   wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       adj_load,
  input  wire logic       adj_dir_in,
  input  wire logic       ph_adj_in,
  output logic      [7:0] device_number,
  output logic      [7:0] bank_number,
  output logic      [7:0] lane_reg,
  output logic      [7:0] scr_reg,
  output logic      [7:0] frame_reg
);

  typedef struct packed {
    logic [7:0] dev;
    logic [7:0] bank;
    logic [7:0] lid;
    logic [7:0] payload_randomizer_enable;
    logic [7:0] frm;
  } slr_cfg_t;

  slr_cfg_t st_ff;
  slr_cfg_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    unique case (wr_sel)
      SEL_NONE: ;
      SEL_DEV:  nxt_st.dev = wr_data;
      SEL_BANK: nxt_st.bank = wr_data;
      SEL_LANE_NUMBER_FIELD: nxt_st.lid = wr_data & (HAS_ADJ ? MASK_LID_ADJ : MASK_LID_NO);
      SEL_SCR:  nxt_st.payload_randomizer_enable = wr_data & MASK_SCR;
      SEL_FRM:  nxt_st.frm = wr_data;
      default:  ;
    endcase
    // lane 0 link information wins over a software write in the same cycle
    if (HAS_ADJ && adj_load) begin
      nxt_st.lid[POS_ADJ_DIR] = adj_dir_in;
      nxt_st.lid[POS_PH_ADJ]  = ph_adj_in;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '{dev: RST_DEV, bank: RST_BANK, lid: RST_LANE_NUMBER_FIELD, payload_randomizer_enable: RST_SCR, frm: RST_FRM};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign device_number = st_ff.dev;
  assign bank_number   = st_ff.bank;
  assign lane_reg      = st_ff.lid;
  assign scr_reg       = st_ff.payload_randomizer_enable;
  assign frame_reg     = st_ff.frm;

endmodule

// *** tb/slr_ilas_source.sv ***
// ---------------------------------------------------------------------------
// ilas configuration sender standing in for the far-end transmitter
// ---------------------------------------------------------------------------
// sends octets 0..13 on one (link,lane) slot after a start pulse.
// assumes slot order link*2+k, k=0 lane 6, k=1 lane 7.
`timescale 1ns/1ns
module slr_ilas_source (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [1:0]  sel,
  input  wire logic [4:0]  lid,
  input  wire logic        bad,
  output logic      [3:0]  ilas_valid,
  output logic      [15:0] ilas_index,
  output logic      [31:0] ilas_octet,
  output logic             busy
);
  logic [4:0] cnt;
  logic [7:0] sum;
  logic [7:0] oct;
  assign busy = (cnt != 5'h0e);
  always_comb begin
    if (cnt == 5'h02) begin
      oct = {3'h0, lid};
    end else if (cnt == 5'h0d) begin
      oct = sum + {7'h00, bad};
    end else begin
      oct = 8'h40 + {3'h0, cnt};
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt        <= 5'h0e;
      sum        <= 8'h00;
      ilas_valid <= 4'h0;
      ilas_index <= 16'h0000;
      ilas_octet <= 32'h0000_0000;
    end else if (start) begin
      cnt <= 5'h00;
      sum <= 8'h00;
    end else if (busy) begin
      ilas_valid <= 4'h1 << sel;
      ilas_index <= {4{cnt[3:0]}};
      ilas_octet <= {4{oct}};
      sum        <= sum + oct;
      cnt        <= cnt + 5'h01;
    end else begin
      // idle lines keep toggling so stale data never looks valid
      ilas_valid <= 4'h0;
      ilas_index <= ~ilas_index;
      ilas_octet <= ~ilas_octet;
    end
  end
endmodule

// *** tb/tb_slr_lane_cfg_regs.sv ***
// ---------------------------------------------------------------------------
// self-checking bench for the paged lane configuration register bank
// ---------------------------------------------------------------------------
// drives the register port, lane 0 info and an ilas sender model.
// assumes LINKS=2 and read data one cycle after the read strobe.
`timescale 1ns/1ns
module tb_slr_lane_cfg_regs;
  import slr_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e;} slr_row_t;
  logic        ref_clk, reset, reg_wr, reg_rd, info_v, info_dir, info_ph, start, bad, busy;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  sel, cfg_scr;
  logic [4:0]  lid;
  logic [3:0]  ilas_valid, mism;
  logic [15:0] ilas_index, cfg_dev, cfg_bank, cfg_oct;
  logic [31:0] ilas_octet;
  logic [9:0]  cfg_lane, cfg_cnt;
  logic        mf_dir, ph_req, core_rst;
  int          failures, check_count;
  int          cycles = 0;
  slr_row_t    rows [10] = '{'{12'h450, 8'ha5, 8'ha5}, '{12'h451, 8'h3c, 8'h3c}, '{12'h452, 8'hff, 8'h7f},
                             '{12'h453, 8'hff, 8'h9f}, '{12'h454, 8'h81, 8'h81}, '{12'h43a, 8'hff, 8'h00},
                             '{12'h43d, 8'hff, 8'h00}, '{12'h43e, 8'hff, 8'h00}, '{12'h442, 8'hff, 8'h00},
                             '{12'h123, 8'hff, 8'h00}};
  slr_lane_cfg_regs dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ilas_valid(ilas_valid), .ilas_index(ilas_index),
    .ilas_octet(ilas_octet), .lane0_info_valid(info_v), .lane0_adj_dir(info_dir), .lane0_ph_adj(info_ph),
    .cfg_device_number(cfg_dev), .cfg_bank_number(cfg_bank), .cfg_lane_number(cfg_lane),
    .cfg_descramble_en(cfg_scr), .cfg_lane_count_m1(cfg_cnt), .cfg_octets_m1(cfg_oct),
    .multiframe_adjust_direction(mf_dir), .phase_adjust_request(ph_req),
    .deframer_core_soft_reset(core_rst), .sum_mismatch(mism));
  slr_ilas_source src_u (.ref_clk(ref_clk), .reset(reset), .start(start), .sel(sel), .lid(lid), .bad(bad),
    .ilas_valid(ilas_valid), .ilas_index(ilas_index), .ilas_octet(ilas_octet), .busy(busy));
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("reg_rdata at %h", a), reg_rdata, e);
  endtask
  function automatic logic [7:0] exp_sum(input logic [4:0] l);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 13; i++) s += (i == 2) ? {3'h0, l} : 8'h40 + 8'(i);
    return s;
  endfunction
  task automatic send(input logic [1:0] s, input logic [4:0] l, input logic b);
    @(posedge ref_clk);
    sel   <= s;
    lid   <= l;
    bad   <= b;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    @(negedge ref_clk);
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge ref_clk);
    @(posedge ref_clk);
  endtask
  // -------------------------------------------------------------------------
  // clock and timeout
  // -------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    {reset, reg_wr, reg_rd, info_v, info_dir, info_ph, start, bad} = 8'h80;
    {reg_addr, reg_wdata, sel, lid} = '0;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(12'h453, 8'h87);
    @(negedge ref_clk);
    chk("reg_rdata idle", reg_rdata, 8'h00);
    rd(12'h450, 8'h00);
    rd(12'h452, 8'h00);
    rd(12'h43d, 8'h00);
    wr(12'h475, 8'h08);
    @(negedge ref_clk);
    chk("deframer_core_soft_reset", {7'h00, core_rst}, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk("cfg_octets_m1", cfg_oct[7:0], 8'h81);
    chk("cfg_bank_number", cfg_bank[7:0], 8'h3c);
    chk("cfg_lane_count_m1", {cfg_scr[0], 2'h0, cfg_cnt[4:0]}, 8'h9f);
    chk("lane bits", {mf_dir, ph_req, 1'b0, cfg_lane[4:0]}, 8'hdf);
    @(posedge ref_clk);
    info_v   <= 1'b1;
    info_dir <= 1'b0;
    info_ph  <= 1'b1;
    @(posedge ref_clk);
    info_v <= 1'b0;
    @(negedge ref_clk);
    chk("lane0 adjust", {6'h00, mf_dir, ph_req}, 8'h01);
    rd(12'h452, 8'h3f);
    wr(12'h300, 8'h01);
    rd(12'h300, 8'h01);
    rd(12'h450, 8'h00);
    wr(12'h450, 8'h5a);
    wr(12'h452, 8'hff);
    rd(12'h452, 8'h1f);
    chk("cfg_device_number link1", cfg_dev[15:8], 8'h5a);
    send(2'h3, 5'h0b, 1'b0);
    rd(12'h442, 8'h0b);
    rd(12'h445, exp_sum(5'h0b));
    rd(12'h446, exp_sum(5'h0b));
    chk("sum_mismatch link1 lane7", {7'h00, mism[3]}, 8'h00);
    wr(12'h300, 8'h00);
    rd(12'h450, 8'ha5);
    rd(12'h442, 8'h00);
    send(2'h0, 5'h15, 1'b1);
    rd(12'h43a, 8'h15);
    rd(12'h43d, exp_sum(5'h15) + 8'h01);
    rd(12'h43e, exp_sum(5'h15));
    chk("sum_mismatch link0 lane6", {7'h00, mism[0]}, 8'h01);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(12'h450, 8'h00);
    rd(12'h43d, 8'h00);
    rd(12'h453, 8'h87);
    end_of_test();
  end
endmodule
